// ==== verif/dout_bus_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module dout_bus_monitor
  import dout_bus_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // backplane
  input wire logic [DATA_W-1:0] dev_data,
  input wire logic dev_data_oe,
  input wire logic ctl_data_oe,
  input wire logic sync_strobe,
  input wire logic write_strobe,
  input wire logic read_strobe,
  input wire logic identity_sel,
  input wire logic reply
);
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_b_in);
  // reply is synchronised, so it may lag the strobes by a few cycles
  sequence idle_s;
    (!write_strobe && !read_strobe)[*5];
  endsequence
  sequence sel_s;
    identity_sel[*4];
  endsequence
  sequence ident_rd_s;
    sel_s ##0 dev_data_oe;
  endsequence
  sequence rd_drop_s;
    $fell(read_strobe);
  endsequence
  sequence rd_reply_s;
    $rose(reply) && read_strobe;
  endsequence
  sequence wr_reply_s;
    $rose(reply) && write_strobe;
  endsequence
  sequence sync_up_s;
    $rose(sync_strobe);
  endsequence
  sequence wr_up_s;
    $rose(write_strobe);
  endsequence
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_one_driver: assert property (!(ctl_data_oe && dev_data_oe))
    else $error("both ends drive the data lines");
  a_oe_cause: assert property ($rose(dev_data_oe) |-> read_strobe)
    else $error("data driven without a read strobe");
  a_oe_release: assert property (rd_drop_s |-> ##[1:5] !dev_data_oe)
    else $error("data lines not released");
  a_reply_idle: assert property (idle_s |-> !reply)
    else $error("reply without a strobe");
  a_wr_no_oe: assert property (write_strobe && reply |-> !dev_data_oe)
    else $error("data driven during a write");
  a_rd_reply: assert property (read_strobe && reply |-> dev_data_oe)
    else $error("read reply without data");
  a_reply_late: assert property (rd_reply_s |-> $past(dev_data_oe, 2))
    else $error("read reply too early");
  a_ident_code: assert property (ident_rd_s |-> dev_data == IDENT_CODE)
    else $error("identity code not returned");
  a_sync_reply: assert property (reply |-> sync_strobe)
    else $error("reply outside a bus cycle");
  a_sync_deskew: assert property (sync_up_s |-> $past(ctl_data_oe, 2))
    else $error("sync raised before the address settled");
  a_wr_after_sync: assert property (wr_up_s |-> $past(sync_strobe, 2))
    else $error("write strobe raised without a standing sync");
  a_wr_release: assert property (wr_reply_s |-> ##[1:6] !write_strobe)
    else $error("write strobe held after the reply");
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
  import dout_bus_pkg::*;
  logic mclk_in, rst_b_in, wr_req_in, rd_req_in;
  logic identity_sel_in, output_disable_in, test_sel_in, busy_out, done_out;
  logic [7:0] addr_in, wdata_in, addr_switch_in, reg_m, e8;
  logic [7:0] rdata_out, switch_on_out, indicator_out;
  logic [16:0] exp_q[$];
  logic [16:0] e;
  int fails = 0, n_compared = 0, cyc = 0;
  dout_bus_if bus ();
  dout_byte_port u_dout_byte_port (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .addr_switch_in(addr_switch_in), .bus(bus),
    .switch_on_out(switch_on_out), .indicator_out(indicator_out));
  dout_bus_ctl u_dout_bus_ctl (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .wr_req_in(wr_req_in), .rd_req_in(rd_req_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .identity_sel_in(identity_sel_in),
    .output_disable_in(output_disable_in), .test_sel_in(test_sel_in),
    .busy_out(busy_out),
    .done_out(done_out), .rdata_out(rdata_out), .bus(bus));
  dout_bus_monitor u_mon (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .dev_data(bus.dev_data), .dev_data_oe(bus.dev_data_oe),
    .ctl_data_oe(bus.ctl_data_oe), .sync_strobe(bus.sync_strobe),
    .write_strobe(bus.write_strobe), .read_strobe(bus.read_strobe),
    .identity_sel(bus.identity_sel), .reply(bus.reply));
  // ----------------------------------------
  // checks and report
  // ----------------------------------------
  task automatic chk_val(input string nm, input logic [7:0] x, y);
    n_compared++;
    if (x !== y) begin
      fails++;
      $display("ERROR %s exp %h got %h", nm, x, y);
    end
  endtask
  task automatic chk_out(input logic [7:0] x);
    n_compared++;
    if (switch_on_out !== x || indicator_out !== x) begin
      fails++;
      $display("ERROR outputs exp %h got %h %h", x, switch_on_out,
               indicator_out);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      end_of_test();
    end
  end
  always @(negedge mclk_in) begin
    if (done_out === 1'b1) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("ERROR done exp none got pulse");
      end else begin
        e = exp_q.pop_front();
        if (e[16]) chk_val("rdata", e[15:8], rdata_out);
        chk_out(e[7:0]);
      end
    end
  end
  // ----------------------------------------
  // driver
  // ----------------------------------------
  task automatic xfer(input logic rd, input logic [7:0] a, d,
                      input logic isel, dis);
    do @(negedge mclk_in); while (busy_out !== 1'b0);
    if (!rd && a == addr_switch_in) reg_m = d;
    if (a == addr_switch_in)
      exp_q.push_back({rd, isel ? IDENT_CODE : reg_m, dis ? 8'h00 : reg_m});
    @(posedge mclk_in);
    wr_req_in <= !rd;
    rd_req_in <= rd;
    addr_in <= a;
    wdata_in <= d;
    identity_sel_in <= isel;
    output_disable_in <= dis;
    test_sel_in <= 1'($urandom);
    @(posedge mclk_in);
    wr_req_in <= 1'b0;
    rd_req_in <= 1'b0;
    // busy lags the taken request by a cycle; without this wait the next
    // call would see it low and issue a request the sequencer ignores
    do @(negedge mclk_in); while (busy_out !== 1'b1);
  endtask
  initial begin
    {wr_req_in, rd_req_in, identity_sel_in, output_disable_in} = '0;
    test_sel_in = 1'b0;
    addr_in = '0;
    wdata_in = '0;
    reg_m = OUT_RST;
    rst_b_in = 1'b0;
    void'($urandom(32'h16ab));
    addr_switch_in = 8'($urandom);
    repeat (4) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    @(negedge mclk_in);
    chk_out(OUT_RST);
    xfer(1'b1, addr_switch_in, 8'h00, 1'b0, 1'b0);
    for (int i = 0; i < 16; i++) begin
      e8 = i < 2 ? {8{i[0]}} : 8'($urandom);
      xfer(1'b0, addr_switch_in, e8, 1'b0, i[1]);
      xfer(1'b1, addr_switch_in, 8'h00, i[0], i[2]);
    end
    // a foreign address never replies, so only a reset frees the controller
    xfer(1'b0, addr_switch_in ^ 8'h81, 8'h3c, 1'b0, 1'b0);
    repeat (40) @(negedge mclk_in);
    chk_val("reply", 8'h00, {7'h0, bus.reply});
    chk_val("busy", 8'h01, {7'h0, busy_out});
    chk_out(reg_m);
    @(posedge mclk_in);
    rst_b_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    reg_m = OUT_RST;
    @(negedge mclk_in);
    chk_out(OUT_RST);
    xfer(1'b0, addr_switch_in, 8'h81, 1'b0, 1'b0);
    xfer(1'b1, addr_switch_in, 8'h00, 1'b0, 1'b0);
    do @(negedge mclk_in); while (busy_out !== 1'b0);
    repeat (2) @(negedge mclk_in);
    chk_val("pending", 8'h00, 8'(exp_q.size()));
    end_of_test();
  end
endmodule
`default_nettype wire

// ==== verilog/dout_bus_ctl.sv ====
`timescale 1ns/100ps
`default_nettype none
module dout_bus_ctl
  import dout_bus_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // user command port
  input wire logic wr_req_in,
  input wire logic rd_req_in,
  input wire logic [DATA_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic identity_sel_in,
  input wire logic output_disable_in,
  input wire logic test_sel_in,
  output logic busy_out,
  output logic done_out,
  output logic [DATA_W-1:0] rdata_out,
  // backplane
  dout_bus_if.control bus
);

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_SYNC = 5'b00100,
    ST_XFER = 5'b01000,
    ST_END  = 5'b10000
  } ctl_state_e;

  ctl_state_e state_ff;
  logic is_rd_ff;
  logic [DATA_W-1:0] wdata_ff;
  logic [DATA_W-1:0] addr_ff;
  logic [3:0] cnt_ff;
  logic rep1_ff;
  logic rep_s;

  // ----------------------------------------
  // reply synchroniser
  // ----------------------------------------
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rep1_ff <= 1'b0;
      rep_s <= 1'b0;
    end else begin
      rep1_ff <= bus.reply;
      rep_s <= rep1_ff;
    end
  end

  // ----------------------------------------
  // cycle sequencer
  // ----------------------------------------
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_ff <= ST_IDLE;
      is_rd_ff <= 1'b0;
      wdata_ff <= '0;
      addr_ff <= '0;
      cnt_ff <= CNT_ZERO;
      done_out <= 1'b0;
      rdata_out <= '0;
    end else begin
      done_out <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          cnt_ff <= CNT_ZERO;
          if (wr_req_in || rd_req_in) begin
            is_rd_ff <= rd_req_in;
            addr_ff <= addr_in;
            wdata_ff <= wdata_in;
            state_ff <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          // deskew before sync
          cnt_ff <= cnt_ff + CNT_ONE;
          if (cnt_ff == 4'(DESKEW_CYC)) begin
            cnt_ff <= CNT_ZERO;
            state_ff <= ST_SYNC;
          end
        end
        ST_SYNC: begin
          // allow the device to synchronise and match the address
          cnt_ff <= cnt_ff + CNT_ONE;
          if (cnt_ff == 4'(SYNC_HOLD_CYC)) begin
            state_ff <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (rep_s) begin
            if (is_rd_ff) begin
              rdata_out <= bus.data;
            end
            state_ff <= ST_END;
          end
        end
        ST_END: begin
          // wait for reply to clear before releasing sync
          if (!rep_s) begin
            done_out <= 1'b1;
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bus.ctl_data <= '0;
      bus.ctl_data_oe <= 1'b0;
      bus.sync_strobe <= 1'b0;
      bus.write_strobe <= 1'b0;
      bus.read_strobe <= 1'b0;
      bus.identity_sel <= 1'b0;
      bus.output_disable <= 1'b0;
      bus.test_sel <= 1'b0;
      busy_out <= 1'b0;
    end else begin
      bus.identity_sel <= identity_sel_in;
      bus.output_disable <= output_disable_in;
      bus.test_sel <= test_sel_in;
      busy_out <= (state_ff != ST_IDLE);
      bus.ctl_data <= (state_ff == ST_XFER && !is_rd_ff) ? wdata_ff : addr_ff;
      bus.ctl_data_oe <= (state_ff == ST_ADDR) || (state_ff == ST_SYNC) ||
                         ((state_ff == ST_XFER || state_ff == ST_END) &&
                          !is_rd_ff);
      bus.sync_strobe <= (state_ff == ST_SYNC) || (state_ff == ST_XFER) ||
                         (state_ff == ST_END && rep_s);
      bus.write_strobe <= state_ff == ST_XFER && !is_rd_ff && !rep_s;
      bus.read_strobe <= state_ff == ST_XFER && is_rd_ff && !rep_s;
    end
  end

endmodule
`default_nettype wire

// ==== verilog/dout_bus_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface dout_bus_if;
  import dout_bus_pkg::*;
  logic [DATA_W-1:0] ctl_data;
  logic ctl_data_oe;
  logic [DATA_W-1:0] dev_data;
  logic dev_data_oe;
  logic sync_strobe;
  logic write_strobe;
  logic read_strobe;
  logic identity_sel;
  logic output_disable;
  logic test_sel;
  logic reply;
  // resolved data lines, pulled low when nobody drives
  logic [DATA_W-1:0] data;
  assign data = ctl_data_oe ? ctl_data :
                (dev_data_oe ? dev_data : '0);
  modport device (
    input data, sync_strobe, write_strobe, read_strobe,
    input identity_sel, output_disable, test_sel,
    output dev_data, dev_data_oe, reply
  );
  modport control (
    input data, reply,
    output ctl_data, ctl_data_oe, sync_strobe, write_strobe, read_strobe,
    output identity_sel, output_disable, test_sel
  );
endinterface
`default_nettype wire

// ==== verilog/dout_bus_pkg.sv ====
`default_nettype none
package dout_bus_pkg;
  // byte width of the backplane data lines and of the output register
  localparam int DATA_W = 8;
  // register reset value: all outputs off
  localparam logic [7:0] OUT_RST = 8'h00;
  // identity code returned on a read when identity select is set (arbitrary)
  localparam logic [7:0] IDENT_CODE = 8'h5a;
  // delay from read gate rising to reply, in cycles of mclk (25 ns)
  localparam int REPLY_DLY_NS = 50;
  localparam int CLK_NS = 25;
  localparam int REPLY_DLY_CYC =
    (REPLY_DLY_NS + CLK_NS - 1) / CLK_NS < 1 ? 1 :
    (REPLY_DLY_NS + CLK_NS - 1) / CLK_NS;
  // deskew delay from address placement to sync strobe, in cycles
  localparam int DESKEW_NS = 50;
  localparam int DESKEW_CYC =
    (DESKEW_NS + CLK_NS - 1) / CLK_NS < 1 ? 1 :
    (DESKEW_NS + CLK_NS - 1) / CLK_NS;
  // sync stands this long before a data strobe, so that the far end's
  // two-stage input synchroniser has settled its address match
  localparam int SYNC_HOLD_CYC = DESKEW_CYC + 3;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_ZERO = 4'h0;
endpackage
`default_nettype wire

// ==== verilog/dout_byte_port.sv ====
// Contract
// - data lines feed comparator and register
// - disable bit forces all outputs off
// - each gated bit drives switch and indicator
// - sync after deskew, then address match
// - write strobe loads data byte
// - reply is write strobe and match
// - controller drops write strobe after reply
// - register changes only on own writes
// - read gate drives selected byte
// - identity select returns identity code
// - reply follows read gate after delay
// - read strobe drop releases data lines
// - test bit has no effect
// - single switch-selected address
`timescale 1ns/100ps
`default_nettype none
module dout_byte_port
  import dout_bus_pkg::*;
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_b_in,
  // address switch setting
  input wire logic [DATA_W-1:0] addr_switch_in,
  // backplane
  dout_bus_if.device bus,
  // field side
  output logic [DATA_W-1:0] switch_on_out,
  output logic [DATA_W-1:0] indicator_out
);

  // ----------------------------------------
  // elaboration checks and helpers
  // ----------------------------------------
  // the read reply delay counter below is four bits wide
  if (REPLY_DLY_CYC < 1 || REPLY_DLY_CYC > 15) begin : g_bad_dly
    $error("reply delay does not fit the delay counter");
  end

  // inhibit blanks every bit but keeps the register, so clearing the
  // disable bit brings the last written byte straight back
  function automatic logic [DATA_W-1:0] gate_out(
    input logic [DATA_W-1:0] val,
    input logic dis
  );
    return dis ? '0 : val;
  endfunction

  // ----------------------------------------
  // address switch synchroniser
  // ----------------------------------------
  // the switch is a pin; a setting changed while running must not reach
  // the comparator half-settled
  logic [DATA_W-1:0] sw1_ff;
  logic [DATA_W-1:0] sw2_ff;

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sw1_ff <= '0;
      sw2_ff <= '0;
    end else begin
      sw1_ff <= addr_switch_in;
      sw2_ff <= sw1_ff;
    end
  end

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  // the backplane is an outside domain; two stages before any logic
  logic [DATA_W+4:0] sync1_ff;
  logic [DATA_W+4:0] sync2_ff;
  logic [DATA_W-1:0] data_s;
  logic sync_s;
  logic wr_s;
  logic rd_s;
  logic idsel_s;
  logic dis_s;

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= {bus.sync_strobe, bus.write_strobe, bus.read_strobe,
                   bus.identity_sel, bus.output_disable, bus.data};
      sync2_ff <= sync1_ff;
    end
  end

  // test_sel is deliberately never sampled
  assign {sync_s, wr_s, rd_s, idsel_s, dis_s, data_s} = sync2_ff;

  // ----------------------------------------
  // address match
  // ----------------------------------------
  logic match_ff;
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      match_ff <= 1'b0;
    end else if (!sync_s) begin
      match_ff <= 1'b0;
    end else if (!match_ff && !wr_s && !rd_s) begin
      // address compared while sync stands, before any data strobe
      match_ff <= (data_s == sw2_ff);
    end
  end

  // ----------------------------------------
  // output register and gating
  // ----------------------------------------
  logic [DATA_W-1:0] out_reg_ff;
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      out_reg_ff <= OUT_RST;
    end else if (wr_s && match_ff) begin
      out_reg_ff <= data_s;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      switch_on_out <= '0;
      indicator_out <= '0;
    end else begin
      switch_on_out <= gate_out(out_reg_ff, dis_s);
      indicator_out <= gate_out(out_reg_ff, dis_s);
    end
  end

  // ----------------------------------------
  // read path and reply
  // ----------------------------------------
  logic gate_ff;
  logic [3:0] rdly_ff;
  logic [DATA_W-1:0] dout_ff;
  logic reply_ff;

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      gate_ff <= 1'b0;
      dout_ff <= '0;
    end else begin
      gate_ff <= rd_s && match_ff;
      dout_ff <= idsel_s ? IDENT_CODE : out_reg_ff;
    end
  end

  // reply delay after the read gate rises
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdly_ff <= CNT_ZERO;
    end else if (!gate_ff) begin
      rdly_ff <= CNT_ZERO;
    end else if (rdly_ff != 4'(REPLY_DLY_CYC)) begin
      rdly_ff <= rdly_ff + CNT_ONE;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reply_ff <= 1'b0;
    end else begin
      // write reply is immediate; read reply waits for data to settle
      reply_ff <= (wr_s && match_ff) ||
                  (gate_ff && rdly_ff == 4'(REPLY_DLY_CYC));
    end
  end

  assign bus.dev_data = dout_ff;
  assign bus.dev_data_oe = gate_ff;
  assign bus.reply = reply_ff;

endmodule
`default_nettype wire
